// >>> logic/sfb_consts.vh
// Constants for the status flag bit operation block
`ifndef SFB_CONSTS_VH
`define SFB_CONSTS_VH

// ==========================================================
// Status register bit positions
`define SFB_BIT_C        3'd0
`define SFB_BIT_Z        3'd1
`define SFB_BIT_N        3'd2
`define SFB_BIT_V        3'd3
`define SFB_BIT_S        3'd4
`define SFB_BIT_H        3'd5
`define SFB_BIT_T        3'd6
`define SFB_BIT_I        3'd7
`define SFB_STATUS_RESET 8'h00

// ==========================================================
// Operation codes from the decoder
`define SFB_OP_W                    5
`define SFB_OP_NONE                 5'h00
`define SFB_OP_STATUS_BIT_SET       5'h01
`define SFB_OP_STATUS_BIT_CLEAR     5'h02
`define SFB_OP_REG_BIT_TO_TRANSFER  5'h03
`define SFB_OP_TRANSFER_TO_REG_BIT  5'h04
`define SFB_OP_CARRY_RAISE          5'h05
`define SFB_OP_CARRY_LOWER          5'h06
`define SFB_OP_NEGATIVE_RAISE       5'h07
`define SFB_OP_NEGATIVE_LOWER       5'h08
`define SFB_OP_ZERO_RAISE           5'h09
`define SFB_OP_ZERO_LOWER           5'h0a
`define SFB_OP_INTERRUPT_ENABLE     5'h0b
`define SFB_OP_INTERRUPT_DISABLE    5'h0c
`define SFB_OP_SIGN_RAISE           5'h0d
`define SFB_OP_SIGN_LOWER           5'h0e
`define SFB_OP_OVERFLOW_RAISE       5'h0f
`define SFB_OP_OVERFLOW_LOWER       5'h10
`define SFB_OP_TRANSFER_BIT_RAISE   5'h11
`define SFB_OP_TRANSFER_BIT_LOWER   5'h12
`define SFB_OP_HALF_CARRY_RAISE     5'h13
`define SFB_OP_HALF_CARRY_LOWER     5'h14

// ==========================================================
// Command word field positions
`define SFB_CMD_OP_LSB   0
`define SFB_CMD_IDX_LSB  8
`define SFB_CMD_VAL_LSB  16

// ==========================================================
// Register map (APB byte addresses)
`define SFB_ADDR_STATUS  12'h000
`define SFB_ADDR_CMD     12'h004
`define SFB_ADDR_RESULT  12'h008
`define SFB_ADDR_COUNT   12'h00c

`endif

// >>> logic/sfb_bit_write.v
// Single bit replace: writes one bit of a byte at a chosen index
`timescale 1ns/10ps
`default_nettype none
module sfb_bit_write #(
   parameter W = 8
) (
   input  wire [W-1:0] i_value,
   input  wire [2:0]   i_index,
   input  wire         i_bit,
   output reg  [W-1:0] o_value
);
   integer k;
   always @* begin
      o_value = i_value;
      for (k = 0; k < W; k = k + 1) begin
         if (i_index == k[2:0]) begin
            o_value[k] = i_bit;
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/sfb_flag_ops.v
// Status flag and bit transfer execution unit with an APB register view
// Notes on behaviour
// RULE_01 - Indexed status bit set/clear, one cycle
// RULE_02 - Register bit copied into transfer bit
// RULE_03 - Transfer bit copied into destination register bit
// RULE_04 - Carry raise/lower, carry only
// RULE_05 - Negative raise/lower, negative only
// RULE_06 - Zero raise/lower, zero only
// RULE_07 - Interrupt enable/disable flag, one cycle
// RULE_08 - Sign raise/lower, sign only
// RULE_09 - Overflow raise/lower, one cycle
// RULE_10 - Transfer bit raise/lower, one cycle
// RULE_11 - Half carry raise, others unchanged
// RULE_12 - Half carry lower, others unchanged
`timescale 1ns/10ps
`default_nettype none
`include "sfb_consts.vh"
module sfb_flag_ops #(
   parameter W = 8
) (
   input  wire                   i_clock,
   input  wire                   i_rst,
   input  wire                   i_op_valid,
   input  wire [`SFB_OP_W-1:0]   i_op,
   input  wire [2:0]             i_bit_index,
   input  wire [W-1:0]           i_reg_value,
   input  wire [11:0]            i_paddr,
   input  wire                   i_psel,
   input  wire                   i_penable,
   input  wire                   i_pwrite,
   input  wire [31:0]            i_pwdata,
   input  wire [3:0]             i_pstrb,
   output reg  [31:0]            o_prdata,
   output reg                    o_pready,
   output reg                    o_pslverr,
   output reg  [7:0]             o_status,
   output reg  [W-1:0]           o_reg_result,
   output reg                    o_reg_write,
   output reg                    o_done
);
   // ==========================================================
   // Operation select: core port wins over a software command
   reg                  sw_cmd_q;
   reg [`SFB_OP_W-1:0]  sw_op_q;
   reg [2:0]            sw_idx_q;
   reg [W-1:0]          sw_val_q;
   reg [15:0]           count_q;

   wire                 use_core = i_op_valid;
   wire                 go       = i_op_valid | sw_cmd_q;
   wire [`SFB_OP_W-1:0] op       = use_core ? i_op : sw_op_q;
   wire [2:0]           idx      = use_core ? i_bit_index : sw_idx_q;
   wire [W-1:0]         rval     = use_core ? i_reg_value : sw_val_q;

   // ==========================================================
   // Flag decode
   reg       wr_flag;
   reg [2:0] flag_pos;
   reg       flag_val;
   reg       wr_reg;
   always @* begin
      wr_flag  = 1'b1;
      flag_pos = idx;
      flag_val = 1'b0;
      wr_reg   = 1'b0;
      case (op)
         `SFB_OP_STATUS_BIT_SET: begin
            flag_val = 1'b1; // see RULE_01
         end
         `SFB_OP_STATUS_BIT_CLEAR: begin
            flag_val = 1'b0; // see RULE_01
         end
         `SFB_OP_REG_BIT_TO_TRANSFER: begin
            flag_pos = `SFB_BIT_T;
            flag_val = rval[idx]; // see RULE_02
         end
         `SFB_OP_TRANSFER_TO_REG_BIT: begin
            wr_flag = 1'b0; // see RULE_03
            wr_reg  = 1'b1;
         end
         `SFB_OP_CARRY_RAISE: begin
            flag_pos = `SFB_BIT_C;
            flag_val = 1'b1; // see RULE_04
         end
         `SFB_OP_CARRY_LOWER: begin
            flag_pos = `SFB_BIT_C; // see RULE_04
         end
         `SFB_OP_NEGATIVE_RAISE: begin
            flag_pos = `SFB_BIT_N;
            flag_val = 1'b1; // see RULE_05
         end
         `SFB_OP_NEGATIVE_LOWER: begin
            flag_pos = `SFB_BIT_N; // see RULE_05
         end
         `SFB_OP_ZERO_RAISE: begin
            flag_pos = `SFB_BIT_Z;
            flag_val = 1'b1; // see RULE_06
         end
         `SFB_OP_ZERO_LOWER: begin
            flag_pos = `SFB_BIT_Z; // see RULE_06
         end
         `SFB_OP_INTERRUPT_ENABLE: begin
            flag_pos = `SFB_BIT_I;
            flag_val = 1'b1; // see RULE_07
         end
         `SFB_OP_INTERRUPT_DISABLE: begin
            flag_pos = `SFB_BIT_I; // see RULE_07
         end
         `SFB_OP_SIGN_RAISE: begin
            flag_pos = `SFB_BIT_S;
            flag_val = 1'b1; // see RULE_08
         end
         `SFB_OP_SIGN_LOWER: begin
            flag_pos = `SFB_BIT_S; // see RULE_08
         end
         `SFB_OP_OVERFLOW_RAISE: begin
            flag_pos = `SFB_BIT_V;
            flag_val = 1'b1; // see RULE_09
         end
         `SFB_OP_OVERFLOW_LOWER: begin
            flag_pos = `SFB_BIT_V; // see RULE_09
         end
         `SFB_OP_TRANSFER_BIT_RAISE: begin
            flag_pos = `SFB_BIT_T;
            flag_val = 1'b1; // see RULE_10
         end
         `SFB_OP_TRANSFER_BIT_LOWER: begin
            flag_pos = `SFB_BIT_T; // see RULE_10
         end
         `SFB_OP_HALF_CARRY_RAISE: begin
            flag_pos = `SFB_BIT_H;
            flag_val = 1'b1; // see RULE_11
         end
         `SFB_OP_HALF_CARRY_LOWER: begin
            flag_pos = `SFB_BIT_H; // see RULE_12
         end
         default: begin
            wr_flag = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Bit replacement datapaths
   wire [7:0]   status_new;
   wire [W-1:0] reg_new;

   sfb_bit_write #(.W(8)) u_status_bit (
      .i_value (o_status),
      .i_index (flag_pos),
      .i_bit   (flag_val),
      .o_value (status_new)
   );

   sfb_bit_write #(.W(W)) u_reg_bit (
      .i_value (rval),
      .i_index (idx),
      .i_bit   (o_status[`SFB_BIT_T]),
      .o_value (reg_new)
   );

   // ==========================================================
   // APB decode; one wait state, pready registered from the first access-phase cycle
   wire apb_acc = i_psel & i_penable & ~o_pready;
   wire apb_wr  = apb_acc & i_pwrite;
   wire apb_rd  = apb_acc & ~i_pwrite;
   wire hit_st  = (i_paddr == `SFB_ADDR_STATUS);
   wire hit_cmd = (i_paddr == `SFB_ADDR_CMD);
   wire hit_res = (i_paddr == `SFB_ADDR_RESULT);
   wire hit_cnt = (i_paddr == `SFB_ADDR_COUNT);
   wire mapped  = hit_st | hit_cmd | hit_res | hit_cnt;
   // Software writes to status yield to a same-cycle instruction that writes a flag
   wire sw_st_wr = apb_wr & hit_st & i_pstrb[0] & ~(go & wr_flag);

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_st) begin
         rd_mux[7:0] = o_status;
      end
      if (hit_cmd) begin
         rd_mux[`SFB_CMD_OP_LSB +: `SFB_OP_W] = sw_op_q;
         rd_mux[`SFB_CMD_IDX_LSB +: 3]        = sw_idx_q;
         rd_mux[`SFB_CMD_VAL_LSB +: 8]        = sw_val_q[7:0];
      end
      if (hit_res) begin
         rd_mux[7:0] = o_reg_result[7:0];
      end
      if (hit_cnt) begin
         rd_mux[15:0] = count_q;
      end
   end

   // ==========================================================
   // Next values
   // Precedence is settled here once so the clocked blocks stay plain
   reg [7:0]    status_d;
   reg [W-1:0]  reg_result_d;
   reg [15:0]   count_d;
   reg          sw_cmd_d;
   reg [31:0]   prdata_d;

   always @* begin
      status_d = o_status;
      if (go & wr_flag) begin
         status_d = status_new; // see RULE_01
      end else if (sw_st_wr) begin
         status_d = i_pwdata[7:0];
      end
   end

   always @* begin
      reg_result_d = o_reg_result;
      if (go & wr_reg) begin
         reg_result_d = reg_new; // see RULE_03
      end
   end

   always @* begin
      count_d = count_q;
      if (go) begin
         count_d = count_q + 16'h0001;
      end
      // A clear that meets an op in the same cycle wins
      if (apb_wr & hit_cnt) begin
         count_d = 16'h0000;
      end
   end

   always @* begin
      sw_cmd_d = sw_cmd_q;
      // A pending software command waits while the core is busy
      if (sw_cmd_q & ~use_core) begin
         sw_cmd_d = 1'b0;
      end
      if (apb_wr & hit_cmd) begin
         sw_cmd_d = 1'b1;
      end
   end

   // Read data is held between reads so a late sample still sees it
   always @* begin
      prdata_d = o_prdata;
      if (apb_rd) begin
         prdata_d = rd_mux;
      end
   end

   // ==========================================================
   // Status register
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_status <= `SFB_STATUS_RESET;
      end else begin
         o_status <= status_d;
      end
   end

   // ==========================================================
   // Register write-back and completion strobes
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_result <= {W{1'b0}};
         o_reg_write  <= 1'b0;
         o_done       <= 1'b0;
      end else begin
         o_reg_result <= reg_result_d;
         o_reg_write  <= go & wr_reg; // see RULE_03
         o_done       <= go;
      end
   end

   // ==========================================================
   // Software command word and op counter
   always @(posedge i_clock) begin
      if (i_rst) begin
         sw_cmd_q <= 1'b0;
         sw_op_q  <= `SFB_OP_NONE;
         sw_idx_q <= 3'h0;
         sw_val_q <= {W{1'b0}};
         count_q  <= 16'h0000;
      end else begin
         sw_cmd_q <= sw_cmd_d;
         count_q  <= count_d;
         if (apb_wr & hit_cmd) begin
            sw_op_q  <= i_pwdata[`SFB_CMD_OP_LSB +: `SFB_OP_W];
            sw_idx_q <= i_pwdata[`SFB_CMD_IDX_LSB +: 3];
            sw_val_q <= i_pwdata[`SFB_CMD_VAL_LSB +: W];
         end
      end
   end

   // ==========================================================
   // APB response: one wait state on every access
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_prdata  <= prdata_d;
         o_pready  <= apb_acc;
         o_pslverr <= apb_acc & ~mapped;
      end
   end
endmodule
`default_nettype wire

// >>> verif/sfb_flag_ops_monitor.sv
// Port checker for the status flag and bit transfer unit
`timescale 1ns/10ps
`default_nettype none
module sfb_flag_ops_monitor #(
   parameter W = 8
) (
   input wire logic         i_clock,
   input wire logic         i_rst,
   input wire logic         i_op_valid,
   input wire logic [4:0]   i_op,
   input wire logic [2:0]   i_bit_index,
   input wire logic [W-1:0] i_reg_value,
   input wire logic [7:0]   o_status,
   input wire logic [W-1:0] o_reg_result,
   input wire logic         o_reg_write,
   input wire logic         o_done
);
   // =====
   // Last taken op and the state it saw
   // Flag bit of each implicit raise/lower pair, in op code order
   localparam [23:0] FLAG_MAP = {3'h5, 3'h6, 3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
   reg  [4:0]   op_q;
   reg  [7:0]   st_q;
   reg  [W-1:0] rv_q;
   reg  [2:0]   ix_q;
   wire [4:0]   pair = (op_q - 5'h05) >> 1;
   wire [2:0]   fb = FLAG_MAP[3 * pair[2:0] +: 3];
   always @(posedge i_clock) begin
      op_q <= (i_op_valid && !i_rst) ? i_op : 5'h00;
      st_q <= o_status;
      rv_q <= i_reg_value;
      ix_q <= i_bit_index;
   end
   function automatic [7:0] fx(input [7:0] v, input [2:0] b, input x);
      begin
         fx = v;
         fx[b] = x;
      end
   endfunction
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // =====
   // Assertions
   sequence s_take; i_op_valid; endsequence
   sequence s_answer; o_done && (o_reg_write == (op_q == 5'h04)); endsequence
   property p_done; s_take |=> s_answer; endproperty
   property p_index; op_q inside {5'h01, 5'h02} |-> o_status == fx(st_q, ix_q, !op_q[1]); endproperty
   property p_to_t; op_q == 5'h03 |-> o_status == fx(st_q, 3'h6, rv_q[ix_q]); endproperty
   property p_from_t;
      op_q == 5'h04 |-> o_status == st_q && o_reg_result == fx(rv_q, ix_q, st_q[6]);
   endproperty
   property p_cnz; op_q inside {[5'h05:5'h0a]} |-> o_status == fx(st_q, fb, op_q[0]); endproperty
   property p_is; op_q inside {[5'h0b:5'h0e]} |-> o_status == fx(st_q, fb, op_q[0]); endproperty
   property p_vt; op_q inside {[5'h0f:5'h12]} |-> o_status == fx(st_q, fb, op_q[0]); endproperty
   property p_h; op_q inside {5'h13, 5'h14} |-> o_status == fx(st_q, fb, op_q[0]); endproperty
   a_done: assert property (p_done) else $error("op not answered next cycle");
   a_index: assert property (p_index) else $error("indexed bit op wrong");
   a_to_t: assert property (p_to_t) else $error("bit to transfer wrong");
   a_from_t: assert property (p_from_t) else $error("transfer to reg wrong");
   a_cnz: assert property (p_cnz) else $error("carry/neg/zero op wrong");
   a_is: assert property (p_is) else $error("interrupt/sign op wrong");
   a_vt: assert property (p_vt) else $error("overflow/transfer op wrong");
   a_h: assert property (p_h) else $error("half carry op wrong");
endmodule
bind sfb_flag_ops sfb_flag_ops_monitor #(.W(W)) i_mon (
   .i_clock(i_clock), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op),
   .i_bit_index(i_bit_index), .i_reg_value(i_reg_value), .o_status(o_status),
   .o_reg_result(o_reg_result), .o_reg_write(o_reg_write), .o_done(o_done));
`default_nettype wire

// >>> verif/sfb_regfile_model.sv
// Register file stand-in that feeds and takes back the unit's register value
`timescale 1ns/10ps
`default_nettype none
module sfb_regfile_model (
   input  wire logic       i_clock,
   input  wire logic       i_load,
   input  wire logic [7:0] i_load_value,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wr_value,
   output wire logic [7:0] o_value
);
   logic [7:0] r_q;
   // Write-back is kept so a later op can read it with the load bypass off
   always @(posedge i_clock) begin
      if (i_wr) begin
         r_q <= i_wr_value;
      end
   end
   assign o_value = i_load ? i_load_value : r_q;
endmodule
`default_nettype wire

// >>> verif/status_flag_bit_ops_tb_top.sv
// Testbench of the status flag and bit transfer unit
`timescale 1ns/10ps
`default_nettype none
module status_flag_bit_ops_tb_top;
   logic i_clock = 0, i_rst = 1, op_valid = 0, load = 1, psel = 0, penable = 0, pwrite = 0, serr;
   logic [4:0] op = 0;
   logic [2:0] idx = 0;
   logic [7:0] load_value = 0, reg_value, status, reg_result;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, prdata, r;
   logic pready, pslverr, reg_write, done;
   integer err_count = 0, cmp_count = 0, cyc = 0, i;
   // Rows: {op, index}, register value, status after, register result
   localparam [31:0] ROWS [0:24] = '{32'h28000100, 32'h38000500, 32'h48000700,
      32'h58008700, 32'h68009700, 32'h78009f00, 32'h8800df00, 32'h9800ff00, 32'h2300ff08,
      32'h3000fe00, 32'h4000fa00, 32'h5000f800, 32'h60007800, 32'h70006800, 32'h80006000,
      32'ha0004000, 32'h90000000, 32'h27ff007f, 32'h1a044000, 32'h1afb0000, 32'h0d002000,
      32'h08002100, 32'h15000100, 32'h0f008100, 32'h10008000};
   sfb_flag_ops i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_op_valid(op_valid), .i_op(op),
      .i_bit_index(idx), .i_reg_value(reg_value), .i_paddr(paddr), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .i_pstrb(4'hf),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_status(status),
      .o_reg_result(reg_result), .o_reg_write(reg_write), .o_done(done));
   sfb_regfile_model i_regs (.i_clock(i_clock), .i_load(load), .i_load_value(load_value),
      .i_wr(reg_write), .i_wr_value(reg_result), .o_value(reg_value));
   always #2.5 i_clock = ~i_clock;
   task give_verdict;
      begin
         $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   always @(posedge i_clock) begin
      cyc = cyc + 1;
      if (cyc == 500) begin
         err_count = err_count + 1;
         give_verdict;
      end
   end
   task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // =====
   // APB master: holds the request until pready is sampled high
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge i_clock);
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
         @(posedge i_clock);
         penable <= 1;
         @(posedge i_clock);
         // Only the cycle ceiling ends a wait for the slave
         while (pready !== 1'b1) begin
            @(posedge i_clock);
         end
         rd = prdata;
         serr = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   // =====
   // Main sequence: rows back to back, then hand-written cases
   initial begin
      repeat (3) @(posedge i_clock);
      i_rst <= 0;
      for (i = 0; i <= 25; i = i + 1) begin
         @(posedge i_clock);
         op_valid <= (i < 25);
         {op, idx, load_value} <= ROWS[i % 25][31:16];
         if (i > 0) begin
            #1;
            r = ROWS[i - 1];
            chk("st_czn", r[10:8], status[2:0]);
            chk("st_vsh", r[13:11], status[5:3]);
            chk("st_ti", r[15:14], status[7:6]);
            chk("done", 1, done);
            chk("reg_write", r[31:27] == 5'h04, reg_write);
            if (r[31:27] == 5'h04) chk("reg_result", r[7:0], reg_result);
         end
      end
      @(posedge i_clock);
      {load, op_valid, op, idx} <= {2'b01, 8'h1e};
      @(posedge i_clock);
      op <= 5'h1f;
      #1 chk("wb_to_t", 32'hc0, status);
      @(posedge i_clock);
      op_valid <= 0;
      #1 chk("unknown_op", 32'h1c0, {done, status});
      apb(0, 12'h008, 0);
      chk("result_rd", 32'h7f, rd);
      @(posedge i_clock);
      i_rst <= 1;
      @(posedge i_clock);
      i_rst <= 0;
      #1 chk("rst_stat", 0, {pready, pslverr, done, reg_write, reg_result, status});
      apb(1, 12'h000, 32'h5a);
      apb(0, 12'h000, 0);
      chk("status_rd", 32'h5a, rd);
      apb(0, 12'h010, 0);
      chk("slverr", 1, serr);
      chk("unmapped", 0, rd);
      apb(1, 12'h004, 32'h05);
      repeat (3) @(posedge i_clock);
      #1 chk("cmd_carry", 32'h5b, status);
      apb(0, 12'h004, 0);
      chk("cmd_rd", 32'h05, rd);
      apb(0, 12'h00c, 0);
      chk("count", 1, rd);
      apb(1, 12'h00c, 0);
      apb(0, 12'h00c, 0);
      chk("count_clr", 0, rd);
      give_verdict;
   end
endmodule
`default_nettype wire
